// File: fomc_pkg.sv
// Package for the fault output and margin control block
`default_nettype none
package fomc_pkg;
   // Register offsets
   localparam logic [7:0] OFS_FA_SEL_LO  = 8'h15;
   localparam logic [7:0] OFS_FA_CFG     = 8'h16;
   localparam logic [7:0] OFS_FB_SEL_LO  = 8'h17;
   localparam logic [7:0] OFS_FB_CFG     = 8'h18;
   localparam logic [7:0] OFS_GPIO_CFG_A = 8'h1c;
   localparam logic [7:0] OFS_GPIO_CFG_B = 8'h1d;
   localparam logic [7:0] OFS_GPIO_CFG_C = 8'h1e;
   localparam logic [7:0] OFS_MARGIN_CTL = 8'h4d;
   localparam logic [7:0] OFS_BANK_NORM  = 8'h00;
   localparam logic [7:0] OFS_BANK_UP    = 8'h66;
   localparam logic [7:0] OFS_BANK_DN    = 8'h72;
   // Field positions in the type and polarity registers and the margin control register
   localparam int POS_OV  = 4;
   localparam int POS_UV  = 5;
   localparam int POS_EW  = 6;
   localparam int POS_POL = 7;
   localparam int POS_MARGIN_CTL = 1;
   // Reset values
   localparam logic [7:0] RST_REG8 = 8'h00;
   // Pin configuration codes
   localparam logic [2:0] PCFG_PP_FAULT  = 3'h3;
   localparam logic [2:0] PCFG_OD_FAULT  = 3'h4;
   localparam logic [2:0] PCFG_MARGIN    = 3'h0;
   localparam logic [2:0] PCFG_SPECIAL   = 3'h7;
   // Channel count
   localparam int NCH = 12;
   // Dac bank selection
   typedef enum logic [1:0] {BANK_NORMAL, BANK_RAISE, BANK_LOWER} fomc_bank_t;
   // Per-channel comparator results
   typedef struct packed {
      logic [NCH-1:0] ov;
      logic [NCH-1:0] uv;
      logic [NCH-1:0] ew;
   } fomc_cmp_t;
   // Register write strobe with data
   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] data;
   } fomc_wr_t;
endpackage
`default_nettype wire

// File: fomc_fault_eval.sv
// One configurable fault output evaluator with hold
`default_nettype none
module fomc_fault_eval (
   input  wire logic                        clock,
   input  wire logic                        rstn,
   input  wire fomc_pkg::fomc_cmp_t         cmp,
   input  wire logic [fomc_pkg::NCH-1:0]    sel,
   input  wire logic [7:0]                  cfg,
   input  wire logic                        hold,
   output logic                             level_ff,
   output logic                             fault_ff
);
   logic [fomc_pkg::NCH-1:0] hit;
   logic                     nxt_fault;

   // Per channel: any enabled threshold type violated
   genvar g;
   generate
      for (g = 0; g < fomc_pkg::NCH; g++) begin : g_ch
         assign hit[g] = sel[g] & ((cmp.ov[g] & cfg[fomc_pkg::POS_OV]) |
                                   (cmp.uv[g] & cfg[fomc_pkg::POS_UV]) |
                                   (cmp.ew[g] & cfg[fomc_pkg::POS_EW]));
      end
   endgenerate

   assign nxt_fault = |hit;

   // Held state freezes the raw flag too, so release is clean
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fault_ff <= 1'b0;
      end else if (!hold) begin
         fault_ff <= nxt_fault;
      end
   end

   // polarity, idle level; latched during hold
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         level_ff <= 1'b1;
      end else if (!hold) begin
         level_ff <= nxt_fault ~^ cfg[fomc_pkg::POS_POL];
      end
   end

   a_hold_freeze: assert property (@(posedge clock) disable iff (!rstn)
      hold |=> $stable(level_ff)) else $error("fault level moved during hold");
   a_idle_level: assert property (@(posedge clock) disable iff (!rstn)
      (!hold && !nxt_fault) |=> (level_ff == !$past(cfg[fomc_pkg::POS_POL])))
      else $error("idle fault level wrong");
   a_or_channels: assert property (@(posedge clock) disable iff (!rstn)
      (!hold && (|hit)) |=> fault_ff) else $error("selected fault not seen");
endmodule
`default_nettype wire

// File: fomc_top.sv
// Fault output and margin control top level
`default_nettype none
module fomc_top (
   input  wire logic                     clock,
   input  wire logic                     rstn,
   input  wire fomc_pkg::fomc_wr_t       wr,
   input  wire logic                     variant_12ch,
   input  wire fomc_pkg::fomc_cmp_t      cmp,
   input  wire logic                     seq_fault_evt,
   input  wire logic                     reset_req,
   input  wire logic                     global_fault_in,
   input  wire logic                     log_req,
   input  wire logic [11:0]              dac_en_sw,
   input  wire logic                     pin2_in,
   input  wire logic                     pin3_in,
   input  wire logic                     pin6_in,
   output logic                          pin5_out,
   output logic                          pin5_oe,
   output logic                          pin6_out,
   output logic                          pin6_oe,
   output logic [7:0]                    dac_bank_base,
   output logic [11:0]                   dac_switch_closed,
   output logic                          margin_active,
   output logic                          reset_out_n,
   output logic                          global_fault,
   output logic                          log_write,
   output logic                          supply_kill,
   output logic                          save_fault_data,
   output logic [7:0]                    rd_fa_sel_lo,
   output logic [7:0]                    rd_fa_cfg,
   output logic [7:0]                    rd_fb_sel_lo,
   output logic [7:0]                    rd_fb_cfg
);
   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [7:0] fa_sel_lo_ff, fa_cfg_ff, fb_sel_lo_ff, fb_cfg_ff;
   logic [7:0] gcfg_a_ff, gcfg_b_ff, gcfg_c_ff, mctl_ff;
   logic [2:0] cfg_pin2, cfg_pin3, cfg_pin5, cfg_pin6;

   // Write port, one register per address
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fa_sel_lo_ff <= fomc_pkg::RST_REG8;
         fa_cfg_ff    <= fomc_pkg::RST_REG8;
         fb_sel_lo_ff <= fomc_pkg::RST_REG8;
         fb_cfg_ff    <= fomc_pkg::RST_REG8;
         gcfg_a_ff    <= fomc_pkg::RST_REG8;
         gcfg_b_ff    <= fomc_pkg::RST_REG8;
         gcfg_c_ff    <= fomc_pkg::RST_REG8;
         mctl_ff      <= fomc_pkg::RST_REG8;
      end else if (wr.we) begin
         unique case (wr.addr)
            fomc_pkg::OFS_FA_SEL_LO:  fa_sel_lo_ff <= wr.data;
            fomc_pkg::OFS_FA_CFG:     fa_cfg_ff    <= wr.data;
            fomc_pkg::OFS_FB_SEL_LO:  fb_sel_lo_ff <= wr.data;
            fomc_pkg::OFS_FB_CFG:     fb_cfg_ff    <= wr.data;
            fomc_pkg::OFS_GPIO_CFG_A: gcfg_a_ff    <= wr.data;
            fomc_pkg::OFS_GPIO_CFG_B: gcfg_b_ff    <= wr.data;
            fomc_pkg::OFS_GPIO_CFG_C: gcfg_c_ff    <= wr.data;
            fomc_pkg::OFS_MARGIN_CTL: mctl_ff      <= wr.data;
            default: ;
         endcase
      end
   end

   // Readback of the fault configuration
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rd_fa_sel_lo <= fomc_pkg::RST_REG8;
         rd_fa_cfg    <= fomc_pkg::RST_REG8;
         rd_fb_sel_lo <= fomc_pkg::RST_REG8;
         rd_fb_cfg    <= fomc_pkg::RST_REG8;
      end else begin
         rd_fa_sel_lo <= fa_sel_lo_ff;
         rd_fa_cfg    <= fa_cfg_ff;
         rd_fb_sel_lo <= fb_sel_lo_ff;
         rd_fb_cfg    <= fb_cfg_ff;
      end
   end

   // Pin configuration fields spread over three registers
   assign cfg_pin2 = gcfg_a_ff[5:3];
   assign cfg_pin3 = {gcfg_b_ff[0], gcfg_a_ff[7:6]};
   assign cfg_pin5 = gcfg_b_ff[6:4];
   assign cfg_pin6 = {gcfg_c_ff[1:0], gcfg_b_ff[7]};

   // ------------------------------------------------------------
   // Pin input synchronisers
   // ------------------------------------------------------------
   logic [2:0] s2_ff, s3_ff, s6_ff;
   logic       up_ff, dn_ff, hold_pin_n_ff;

   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s2_ff <= 3'h0;
         s3_ff <= 3'h0;
         s6_ff <= 3'h7;
      end else begin
         s2_ff <= {s2_ff[1:0], pin2_in};
         s3_ff <= {s3_ff[1:0], pin3_in};
         s6_ff <= {s6_ff[1:0], pin6_in};
      end
   end

   // Filtered levels, idle hold pin reads high
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         up_ff         <= 1'b0;
         dn_ff         <= 1'b0;
         hold_pin_n_ff <= 1'b1;
      end else begin
         if (s2_ff[1] == s2_ff[2]) up_ff <= s2_ff[2];
         if (s3_ff[1] == s3_ff[2]) dn_ff <= s3_ff[2];
         if (s6_ff[1] == s6_ff[2]) hold_pin_n_ff <= s6_ff[2];
      end
   end

   // ------------------------------------------------------------
   // Margin hold and bank selection
   // ------------------------------------------------------------
   logic margin_pins, hold, raise, lower;

   // pins act as margin inputs only when configured
   assign margin_pins = (cfg_pin2 == fomc_pkg::PCFG_SPECIAL) && (cfg_pin3 == fomc_pkg::PCFG_SPECIAL);
   assign raise = margin_pins & up_ff;
   assign lower = margin_pins & dn_ff;
   // hold pin low or control bit
   // a selected margin bank holds too, so supplies may move freely
   assign hold = ((cfg_pin6 == fomc_pkg::PCFG_MARGIN) && !hold_pin_n_ff) | mctl_ff[fomc_pkg::POS_MARGIN_CTL]
               | (raise ^ lower);

   // Hold flag out
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         margin_active <= 1'b0;
      end else begin
         margin_active <= hold;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         dac_bank_base     <= fomc_pkg::OFS_BANK_NORM;
         dac_switch_closed <= 12'h000;
      end else if (!raise && lower) begin
         dac_bank_base     <= fomc_pkg::OFS_BANK_UP;
         dac_switch_closed <= 12'hfff;
      end else if (raise && !lower) begin
         dac_bank_base     <= fomc_pkg::OFS_BANK_DN;
         dac_switch_closed <= 12'hfff;
      end else begin
         dac_bank_base     <= fomc_pkg::OFS_BANK_NORM;
         dac_switch_closed <= dac_en_sw;
      end
   end

   // ------------------------------------------------------------
   // Fault outputs
   // ------------------------------------------------------------
   logic [fomc_pkg::NCH-1:0] sel_a, sel_b;
   logic                     lvl_a, lvl_b, flt_a, flt_b;

   // upper four channels exist on the wide variant only
   assign sel_a = {fa_cfg_ff[3:0] & {4{variant_12ch}}, fa_sel_lo_ff};
   assign sel_b = {fb_cfg_ff[3:0] & {4{variant_12ch}}, fb_sel_lo_ff};

   fomc_fault_eval u_eval_a (
      .clock    (clock),
      .rstn     (rstn),
      .cmp      (cmp),
      .sel      (sel_a),
      .cfg      (fa_cfg_ff),
      .hold     (hold),
      .level_ff (lvl_a),
      .fault_ff (flt_a)
   );

   fomc_fault_eval u_eval_b (
      .clock    (clock),
      .rstn     (rstn),
      .cmp      (cmp),
      .sel      (sel_b),
      .cfg      (fb_cfg_ff),
      .hold     (hold),
      .level_ff (lvl_b),
      .fault_ff (flt_b)
   );

   // ------------------------------------------------------------
   // Sequencing fault indicator
   // ------------------------------------------------------------
   logic seqf_ff;

   // sticky until reset; cleared only when rstn goes low
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         seqf_ff <= 1'b0;
      end else if (seq_fault_evt) begin
         seqf_ff <= 1'b1;
      end
   end

   // drop enables, one save pulse for the first event after reset
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         supply_kill     <= 1'b0;
         save_fault_data <= 1'b0;
      end else begin
         supply_kill     <= seqf_ff | seq_fault_evt;
         save_fault_data <= seq_fault_evt & !seqf_ff;
      end
   end

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   // pin 5 carries output A, open drain drives low only
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pin5_out <= 1'b0;
         pin5_oe  <= 1'b0;
      end else if (cfg_pin5 == fomc_pkg::PCFG_PP_FAULT) begin
         pin5_out <= lvl_a;
         pin5_oe  <= 1'b1;
      end else if (cfg_pin5 == fomc_pkg::PCFG_OD_FAULT) begin
         pin5_out <= 1'b0;
         pin5_oe  <= !lvl_a;
      end else begin
         pin5_out <= 1'b0;
         pin5_oe  <= 1'b0;
      end
   end

   // pin 6 carries output B or the open-drain flag
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pin6_out <= 1'b0;
         pin6_oe  <= 1'b0;
      end else if (cfg_pin6 == fomc_pkg::PCFG_PP_FAULT) begin
         pin6_out <= lvl_b;
         pin6_oe  <= 1'b1;
      end else if (cfg_pin6 == fomc_pkg::PCFG_OD_FAULT) begin
         pin6_out <= 1'b0;
         pin6_oe  <= !lvl_b;
      end else if (cfg_pin6 == fomc_pkg::PCFG_SPECIAL) begin
         pin6_out <= 1'b0;
         pin6_oe  <= seqf_ff;
      end else begin
         pin6_out <= 1'b0;
         pin6_oe  <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Reset, global flag and logging gated by hold
   // ------------------------------------------------------------
   // latch reset and global flag while held
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reset_out_n  <= 1'b0;
         global_fault <= 1'b0;
      end else if (!hold) begin
         reset_out_n  <= !reset_req;
         global_fault <= global_fault_in | flt_a | flt_b;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         log_write <= 1'b0;
      end else begin
         log_write <= log_req & !hold;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_bank_upper: assert property (@(posedge clock) disable iff (!rstn)
      (margin_pins && !up_ff && dn_ff) |=> (dac_bank_base == fomc_pkg::OFS_BANK_UP) && (&dac_switch_closed))
      else $error("upper bank not chosen");
   a_bank_lower: assert property (@(posedge clock) disable iff (!rstn)
      (margin_pins && up_ff && !dn_ff) |=> (dac_bank_base == fomc_pkg::OFS_BANK_DN) && (&dac_switch_closed))
      else $error("lower bank not chosen");
   a_bank_normal: assert property (@(posedge clock) disable iff (!rstn)
      (up_ff == dn_ff) |=> (dac_bank_base == fomc_pkg::OFS_BANK_NORM) && (dac_switch_closed == $past(dac_en_sw)))
      else $error("normal bank not chosen");
   a_hold_ctl: assert property (@(posedge clock) disable iff (!rstn)
      mctl_ff[fomc_pkg::POS_MARGIN_CTL] |=> margin_active) else $error("control bit did not hold");
   a_bank_hold: assert property (@(posedge clock) disable iff (!rstn)
      (margin_pins && (up_ff != dn_ff)) |=> margin_active) else $error("margin bank did not hold");
   a_hold_reset: assert property (@(posedge clock) disable iff (!rstn)
      (hold && $past(hold)) |-> $stable(reset_out_n) && $stable(global_fault))
      else $error("reset or flag moved during hold");
   a_no_log: assert property (@(posedge clock) disable iff (!rstn)
      hold |=> !log_write) else $error("log written during hold");
   a_seq_kill: assert property (@(posedge clock) disable iff (!rstn)
      seq_fault_evt |=> supply_kill ##1 supply_kill) else $error("enables not dropped");
   a_pin5_pp: assert property (@(posedge clock) disable iff (!rstn)
      (cfg_pin5 == fomc_pkg::PCFG_PP_FAULT) |=> pin5_oe && (pin5_out == $past(lvl_a)))
      else $error("pin 5 not carrying output A");
   a_seq_pin: assert property (@(posedge clock) disable iff (!rstn)
      (seqf_ff && cfg_pin6 == fomc_pkg::PCFG_SPECIAL) |=> pin6_oe) else $error("sequencing flag not driven");

   c_margin_up:  cover property (@(posedge clock) disable iff (!rstn) dac_bank_base == fomc_pkg::OFS_BANK_UP);
   c_margin_dn:  cover property (@(posedge clock) disable iff (!rstn) dac_bank_base == fomc_pkg::OFS_BANK_DN);
   c_hold_fault: cover property (@(posedge clock) disable iff (!rstn) hold && log_req);
   c_seq_fault:  cover property (@(posedge clock) disable iff (!rstn) save_fault_data);
endmodule
`default_nettype wire

// File: fomc_board.sv
// Board-side partner model: margin pin drivers and fault pin sensing
`default_nettype none
module fomc_board (
   input  wire logic pin5_out,
   input  wire logic pin5_oe,
   input  wire logic pin6_out,
   input  wire logic pin6_oe,
   output logic      pin2_in,
   output logic      pin3_in,
   output logic      pin6_in,
   output logic      pin5_wire,
   output logic      pin6_wire
);
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------
   // Board state
   // ------------------------------------------------------------
   logic raise_lvl = 1'b1;
   logic lower_lvl = 1'b1;
   logic hold_en   = 1'b0;

   assign pin2_in = raise_lvl;
   assign pin3_in = lower_lvl;

   // Fault line has a board pull-up, so open-drain release reads high
   assign pin5_wire = pin5_oe ? pin5_out : 1'b1;

   assign pin6_wire = pin6_oe ? pin6_out : (hold_en ? 1'b0 : 1'b1);
   assign pin6_in   = pin6_wire;

   // Caller changes these just after a rising edge
   task automatic set_margin(input logic up, input logic dn);
      raise_lvl = up;
      lower_lvl = dn;
   endtask

   task automatic hold_pin(input logic on);
      hold_en = on;
   endtask
endmodule
`default_nettype wire

// File: fomc_top_test.sv
// Self-checking testbench for the fault output and margin control block
`default_nettype none
module fomc_top_test;
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int LIMIT = 4000;
   logic                clock           = 1'b0;
   logic                rstn            = 1'b0;
   fomc_pkg::fomc_wr_t  wr              = '0;
   logic                variant_12ch    = 1'b1;
   fomc_pkg::fomc_cmp_t cmp             = '0;
   logic                seq_fault_evt   = 1'b0;
   logic                reset_req       = 1'b0;
   logic                global_fault_in = 1'b0;
   logic                log_req         = 1'b0;
   logic [11:0]         dac_en_sw       = 12'ha5c;
   logic                pin2_in, pin3_in, pin6_in, pin5_wire, pin6_wire;
   logic                pin5_out, pin5_oe, pin6_out, pin6_oe;
   logic [7:0]          dac_bank_base, rd_fa_sel_lo, rd_fa_cfg, rd_fb_sel_lo, rd_fb_cfg;
   logic [11:0]         dac_switch_closed;
   logic                margin_active, reset_out_n, global_fault, log_write, supply_kill, save_fault_data;
   int                  n_fail    = 0;
   int                  tests_run = 0;
   int                  cycles    = 0;

   fomc_top fomc_top_inst (.clock(clock), .rstn(rstn), .wr(wr), .variant_12ch(variant_12ch), .cmp(cmp),
      .seq_fault_evt(seq_fault_evt), .reset_req(reset_req), .global_fault_in(global_fault_in),
      .log_req(log_req), .dac_en_sw(dac_en_sw), .pin2_in(pin2_in), .pin3_in(pin3_in), .pin6_in(pin6_in),
      .pin5_out(pin5_out), .pin5_oe(pin5_oe), .pin6_out(pin6_out), .pin6_oe(pin6_oe),
      .dac_bank_base(dac_bank_base), .dac_switch_closed(dac_switch_closed), .margin_active(margin_active),
      .reset_out_n(reset_out_n), .global_fault(global_fault), .log_write(log_write),
      .supply_kill(supply_kill), .save_fault_data(save_fault_data), .rd_fa_sel_lo(rd_fa_sel_lo),
      .rd_fa_cfg(rd_fa_cfg), .rd_fb_sel_lo(rd_fb_sel_lo), .rd_fb_cfg(rd_fb_cfg));

   fomc_board fomc_board_inst (.pin5_out(pin5_out), .pin5_oe(pin5_oe), .pin6_out(pin6_out),
      .pin6_oe(pin6_oe), .pin2_in(pin2_in), .pin3_in(pin3_in), .pin6_in(pin6_in),
      .pin5_wire(pin5_wire), .pin6_wire(pin6_wire));

   // ------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ------------------------------------------------------------
   always #5 clock = ~clock;

   // Hang guard, generous against roughly 330 cycles of tests
   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask

   // Inputs always move 1 ns after the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // Back to back writes, each entry is address then data
   task automatic wr_regs(input logic [15:0] q[$]);
      foreach (q[i]) begin
         wr = '{1'b1, q[i][15:8], q[i][7:0]};
         cyc(1);
      end
      wr.we = 1'b0;
   endtask

   function automatic fomc_pkg::fomc_cmp_t mk(input int t, input logic [11:0] m);
      fomc_pkg::fomc_cmp_t c;
      c = '0;
      if (t == 0) c.ov = m;
      else if (t == 1) c.uv = m;
      else c.ew = m;
      return c;
   endfunction

   function automatic logic wire_of(input bit b);
      return b ? pin6_wire : pin5_wire;
   endfunction

   task automatic end_of_test;
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      chk(rd_fa_cfg, 8'h00, "reset value");
      chk(rd_fb_cfg, 8'h00, "reset value");
      wr_regs('{16'h155a, 16'h16c3, 16'h173c, 16'h18a5, 16'h30ff});
      cyc(2);
      chk(rd_fa_sel_lo, 8'h5a, "sel a");
      chk(rd_fa_cfg, 8'hc3, "cfg a");
      chk(rd_fb_sel_lo, 8'h3c, "sel b");
      chk(rd_fb_cfg, 8'ha5, "cfg b");
      $display("test regs done");
   endtask

   // One output, one fault type, one polarity; masks pick low, high, unselected channels
   task automatic fault_case(input bit b, input int t, input bit pol);
      logic [11:0] lo_m, hi_m, un_m;
      lo_m = b ? 12'h001 : 12'h010;
      hi_m = b ? 12'h800 : 12'h200;
      un_m = b ? 12'h010 : 12'h001;
      wr_regs('{{(b ? 8'h17 : 8'h15), lo_m[7:0]},
                {(b ? 8'h18 : 8'h16), pol, t == 2, t == 1, t == 0, hi_m[11:8]}});
      cmp = '0;
      cyc(3);
      chk(wire_of(b), !pol, "idle level");
      cmp = mk(t, lo_m);
      cyc(3);
      chk(wire_of(b), pol, "low channel fault");
      cmp = mk((t + 1) % 3, lo_m | hi_m);
      cyc(3);
      chk(wire_of(b), !pol, "type not enabled");
      cmp = mk(t, un_m | hi_m);
      cyc(3);
      chk(wire_of(b), pol, "or of channels");
      cmp = mk(t, un_m);
      cyc(3);
      chk(wire_of(b), !pol, "unselected channel");
      variant_12ch = 1'b0;
      cmp = mk(t, hi_m);
      cyc(3);
      chk(wire_of(b), !pol, "eight channel part");
      variant_12ch = 1'b1;
   endtask

   task automatic t_faults;
      wr_regs('{16'h1db0, 16'h1e01});
      for (int b = 0; b < 2; b++) begin
         for (int t = 0; t < 3; t++) begin
            fault_case(b[0], t, 1'b0);
            fault_case(b[0], t, 1'b1);
         end
      end
      // Open-drain code: low only while asserted, pull-up otherwise
      wr_regs('{16'h1dc0, 16'h1510, 16'h1610});
      cmp = mk(0, 12'h010);
      cyc(3);
      chk(pin5_oe, 1'b1, "od drive");
      chk(pin5_wire, 1'b0, "od low");
      cmp = '0;
      cyc(3);
      chk(pin5_oe, 1'b0, "od release");
      chk(pin5_wire, 1'b1, "od pulled up");
      $display("test faults done");
   endtask

   task automatic t_margin;
      logic        up, dn;
      logic [7:0]  eb;
      wr_regs('{16'h1cf8, 16'h1d31, 16'h1e00});
      for (int i = 0; i < 4; i++) begin
         up = i[1];
         dn = i[0];
         fomc_board_inst.set_margin(up, dn);
         cyc(6);
         eb = (up == dn) ? fomc_pkg::OFS_BANK_NORM : (!up ? fomc_pkg::OFS_BANK_UP : fomc_pkg::OFS_BANK_DN);
         chk(dac_bank_base, eb, "bank base");
         chk(dac_switch_closed, (up == dn) ? dac_en_sw : 12'hfff, "switches");
         chk(margin_active, up != dn, "bank hold");
      end
      fomc_board_inst.set_margin(1'b1, 1'b1);
      $display("test margin done");
   endtask

   task automatic t_hold;
      logic rst_seen, gf_seen;
      wr_regs('{16'h1510, 16'h1690});
      cmp = '0;
      cyc(3);
      chk(margin_active, 1'b0, "hold idle");
      wr_regs('{16'h4d02});
      cyc(2);
      chk(margin_active, 1'b1, "ctl hold");
      rst_seen = reset_out_n;
      gf_seen = global_fault;
      cmp = mk(0, 12'h010);
      reset_req = 1'b1;
      global_fault_in = 1'b1;
      log_req = 1'b1;
      cyc(1);
      chk(log_write, 1'b0, "log blocked");
      log_req = 1'b0;
      cyc(4);
      chk(pin5_wire, 1'b0, "fault frozen");
      chk(reset_out_n, rst_seen, "reset frozen");
      chk(global_fault, gf_seen, "flag frozen");
      wr_regs('{16'h4d00});
      cyc(4);
      chk(pin5_wire, 1'b1, "fault resumes");
      chk(reset_out_n, 1'b0, "reset resumes");
      chk(global_fault, 1'b1, "flag resumes");
      log_req = 1'b1;
      cyc(1);
      chk(log_write, 1'b1, "log passes");
      log_req = 1'b0;
      fomc_board_inst.hold_pin(1'b1);
      cyc(6);
      chk(margin_active, 1'b1, "pin hold");
      fomc_board_inst.hold_pin(1'b0);
      cyc(6);
      chk(margin_active, 1'b0, "pin release");
      reset_req = 1'b0;
      global_fault_in = 1'b0;
      $display("test hold done");
   endtask

   // Last, since the sequencing flag stays until reset
   task automatic t_seq;
      wr_regs('{16'h1db1, 16'h1e03});
      seq_fault_evt = 1'b1;
      cyc(1);
      chk(supply_kill, 1'b1, "enables low");
      chk(save_fault_data, 1'b1, "save");
      seq_fault_evt = 1'b0;
      cyc(1);
      chk(save_fault_data, 1'b0, "save once");
      chk(pin6_oe, 1'b1, "seq flag drive");
      chk(pin6_wire, 1'b0, "seq flag low");
      chk(supply_kill, 1'b1, "enables stay low");
      $display("test seq done");
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      cyc(5);
      chk(pin5_oe, 1'b0, "oe in reset");
      chk(reset_out_n, 1'b0, "reset out");
      rstn = 1'b1;
      cyc(1);
      t_regs();
      t_faults();
      t_margin();
      t_hold();
      t_seq();
      end_of_test();
   end
endmodule
`default_nettype wire
